// file: include/sacc_pkg.sv
package sacc_pkg;
  // register addresses
  localparam logic [7:0] PAIR_CONFIG_ADDR = 8'hBA;
  localparam logic [7:0] CONV_CONFIG_ADDR = 8'hBC;
  localparam logic [7:0] CHAN_SELECT_ADDR = 8'hBB;
  localparam logic [7:0] CONV_CONTROL_ADDR = 8'hE8;
  localparam logic [7:0] RESULT_HIGH_ADDR = 8'hBF;
  localparam logic [7:0] RESULT_LOW_ADDR = 8'hBE;
  // reset values
  localparam logic [7:0] PAIR_CONFIG_RST = 8'h00;
  localparam logic [7:0] CONV_CONFIG_RST = 8'h60;
  localparam logic [7:0] CHAN_SELECT_RST = 8'h00;
  localparam logic [7:0] CONV_CONTROL_RST = 8'h00;
  // control register bit positions
  localparam int CTL_ON = 7;
  localparam int CTL_TRACK = 6;
  localparam int CTL_DONE = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_SRC_HI = 3;
  localparam int CTL_SRC_LO = 2;
  localparam int CTL_LEFT = 0;
  // config register fields
  localparam int CFG_PER_LSB = 5;
  localparam int CFG_GAIN_MSB = 2;
  // start sources
  localparam logic [1:0] SRC_SOFT = 2'h0;
  localparam logic [1:0] SRC_T3 = 2'h1;
  localparam logic [1:0] SRC_STROBE = 2'h2;
  localparam logic [1:0] SRC_T2 = 2'h3;
  // gain codes to the amplifier
  localparam logic [2:0] GAIN_X1 = 3'h0;
  localparam logic [2:0] GAIN_HALF = 3'h6;
  // timing counts in sar clocks, and the temperature channel number
  localparam int TRACK_SAR_CLKS = 3;
  localparam int CONV_SAR_CLKS = 16;
  localparam int TEMP_CHANNEL = 8;
  typedef enum logic [1:0] {SACC_IDLE, SACC_TRACK, SACC_CONV} sacc_state_type;
endpackage

// file: hw/sacc_sar_tick.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_sar_tick
  import sacc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic [2:0] sar_clock_period,
  output logic sar_tick
);
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [3:0] last;

  always_comb
  begin
    // any 1xx code divides by 16
    unique case (sar_clock_period[1:0] | {2{sar_clock_period[2]}})
      2'h0: last = 4'h0;
      2'h1: last = 4'h1;
      2'h2: last = 4'h3;
      default: last = sar_clock_period[2] ? 4'hF : 4'h7;
    endcase
    nxt_cnt = (cnt_ff >= last) ? 4'h0 : 4'(cnt_ff + 4'h1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= nxt_cnt;
  end

  assign sar_tick = (cnt_ff >= last);

  property p_tick_period;
    @(posedge sys_clk) disable iff (rst)
    (sar_clock_period == 3'h0 && $stable(sar_clock_period)) |-> sar_tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("divide-by-one code must tick every clock");
endmodule // sacc_sar_tick
`default_nettype wire

// file: hw/sacc_top.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_top
  import sacc_pkg::*;
#(
  parameter int RES_BITS = 10
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // start sources, chip power state and done interrupt enable
  input wire logic timer3_overflow,
  input wire logic timer2_overflow,
  input wire logic external_convert_strobe,
  input wire logic chip_standby,
  input wire logic done_irq_enable,
  // analog core
  output logic analog_power_on,
  output logic track_on,
  output logic [3:0] mux_positive,
  output logic mux_negative_odd,
  output logic mux_differential,
  output logic [2:0] gain_code,
  output logic sar_step,
  input wire logic [RES_BITS-1:0] core_result,
  // events
  output logic conversion_done_irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] pair_ff, nxt_pair;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] sel_ff, nxt_sel;
  logic [7:0] ctl_ff, nxt_ctl;
  logic [15:0] res_ff, nxt_res;
  logic strobe_ff, nxt_strobe;
  logic irq_ff, nxt_irq;
  sacc_state_type state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic conv_diff_ff, nxt_conv_diff;
  logic sar_tick, start, sel_diff, busy_fall;
  logic [1:0] src;
  logic [15:0] word;

  sacc_sar_tick u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .sar_clock_period(cfg_ff[7:CFG_PER_LSB]),
    .sar_tick(sar_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // start decode
  assign src = ctl_ff[CTL_SRC_HI:CTL_SRC_LO];
  always_comb
  begin
    unique case (src)
      SRC_SOFT: start = sfr_wr && sfr_addr == CONV_CONTROL_ADDR && sfr_wdata[CTL_BUSY];
      SRC_T3: start = timer3_overflow;
      SRC_STROBE: start = external_convert_strobe && !strobe_ff;
      SRC_T2: start = timer2_overflow;
    endcase
  end
  // selected channel differential when its pair bit is set
  assign sel_diff = !sel_ff[3] && pair_ff[sel_ff[2:1]];

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_conv_diff = conv_diff_ff;
    nxt_strobe = external_convert_strobe;
    if (!ctl_ff[CTL_ON])
    begin
      nxt_state = SACC_IDLE;
      nxt_cnt = 5'h0;
    end
    else
    begin
      unique case (state_ff)
        SACC_IDLE:
          if (start)
          begin
            nxt_conv_diff = sel_diff;
            nxt_cnt = 5'h0;
            // strobe mode tracks before the edge, so it converts at once
            if (ctl_ff[CTL_TRACK] && src != SRC_STROBE)
              nxt_state = SACC_TRACK;
            else
              nxt_state = SACC_CONV;
          end
        SACC_TRACK:
          if (sar_tick)
          begin
            if (cnt_ff == 5'(TRACK_SAR_CLKS - 1))
            begin
              nxt_cnt = 5'h0;
              nxt_state = SACC_CONV;
            end
            else
              nxt_cnt = 5'(cnt_ff + 5'h1);
          end
        SACC_CONV:
          if (sar_tick)
          begin
            if (cnt_ff == 5'(CONV_SAR_CLKS - 1))
            begin
              nxt_cnt = 5'h0;
              nxt_state = SACC_IDLE;
            end
            else
              nxt_cnt = 5'(cnt_ff + 5'h1);
          end
      endcase
    end
  end
  assign busy_fall = state_ff == SACC_CONV && nxt_state == SACC_IDLE && ctl_ff[CTL_ON];

  ////////////////////////////////////////////////////////////////////////////
  // result formatting: right-justified differential sign-extends, single-ended zero-extends; left-justified zero-fills low bits
  always_comb
  begin
    word = 16'h0;
    if (ctl_ff[CTL_LEFT])
      word[15 -: RES_BITS] = core_result;
    else
    begin
      word[RES_BITS-1:0] = core_result;
      if (conv_diff_ff)
        word[15:RES_BITS] = {(16-RES_BITS){core_result[RES_BITS-1]}};
    end
    nxt_res = busy_fall ? word : res_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_comb
  begin
    nxt_pair = pair_ff;
    nxt_cfg = cfg_ff;
    nxt_sel = sel_ff;
    nxt_ctl = ctl_ff;
    if (sfr_wr)
    begin
      unique case (sfr_addr)
        PAIR_CONFIG_ADDR: nxt_pair = {4'h0, sfr_wdata[3:0]};
        CONV_CONFIG_ADDR: nxt_cfg = {sfr_wdata[7:5], 2'h0, sfr_wdata[2:0]};
        CHAN_SELECT_ADDR: nxt_sel = {4'h0, sfr_wdata[3:0]};
        CONV_CONTROL_ADDR: nxt_ctl = {sfr_wdata[7:5], ctl_ff[CTL_BUSY], sfr_wdata[3:0]};
        default: ;
      endcase
    end
    nxt_ctl[CTL_BUSY] = (nxt_state != SACC_IDLE);
    if (busy_fall)
      nxt_ctl[CTL_DONE] = 1'b1;
    nxt_irq = busy_fall && done_irq_enable;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pair_ff <= PAIR_CONFIG_RST;
      cfg_ff <= CONV_CONFIG_RST;
      sel_ff <= CHAN_SELECT_RST;
      ctl_ff <= CONV_CONTROL_RST;
      res_ff <= 16'h0;
      strobe_ff <= 1'b0;
      irq_ff <= 1'b0;
      state_ff <= SACC_IDLE;
      cnt_ff <= 5'h0;
      conv_diff_ff <= 1'b0;
    end
    else
    begin
      pair_ff <= nxt_pair;
      cfg_ff <= nxt_cfg;
      sel_ff <= nxt_sel;
      ctl_ff <= nxt_ctl;
      res_ff <= nxt_res;
      strobe_ff <= nxt_strobe;
      irq_ff <= nxt_irq;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      conv_diff_ff <= nxt_conv_diff;
    end
  end

  always_comb
  begin
    unique case (sfr_addr)
      PAIR_CONFIG_ADDR: sfr_rdata = pair_ff;
      CONV_CONFIG_ADDR: sfr_rdata = cfg_ff;
      CHAN_SELECT_ADDR: sfr_rdata = sel_ff;
      CONV_CONTROL_ADDR: sfr_rdata = ctl_ff;
      RESULT_HIGH_ADDR: sfr_rdata = res_ff[15:8];
      RESULT_LOW_ADDR: sfr_rdata = res_ff[7:0];
      default: sfr_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog side
  assign analog_power_on = ctl_ff[CTL_ON];
  always_comb
  begin
    if (!ctl_ff[CTL_ON] || chip_standby)
      track_on = 1'b0;
    else if (!ctl_ff[CTL_TRACK])
      track_on = (state_ff != SACC_CONV);
    else if (src == SRC_STROBE)
      track_on = !external_convert_strobe && state_ff == SACC_IDLE;
    else
      track_on = (state_ff == SACC_TRACK);
  end
  // during a conversion the pair mode captured at start is held
  assign mux_differential = (state_ff == SACC_IDLE) ? sel_diff : conv_diff_ff;
  // a differential pair always converts its even leg as positive
  assign mux_positive = sel_ff[3] ? 4'(TEMP_CHANNEL)
    : (sel_diff ? {1'b0, sel_ff[2:1], 1'b0} : sel_ff[3:0]);
  assign mux_negative_odd = mux_differential;
  // gain passes straight through for every channel, temperature included
  assign gain_code = cfg_ff[CFG_GAIN_MSB:0];
  assign sar_step = (state_ff == SACC_CONV) && sar_tick;
  assign conversion_done_irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_track3;
    (state_ff == SACC_TRACK) [*3];
  endsequence
  // the sequencer may still show a conversion in the cycle the enable drops
  property p_off_idle;
    @(posedge sys_clk) disable iff (rst)
    !ctl_ff[CTL_ON] |-> !track_on ##1 state_ff == SACC_IDLE;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("disabled converter not idle");
  property p_busy_state;
    @(posedge sys_clk) disable iff (rst)
    ctl_ff[CTL_BUSY] == (state_ff != SACC_IDLE);
  endproperty
  a_busy_state: assert property (p_busy_state)
    else $error("busy bit disagrees with sequencer");
  property p_done_set;
    @(posedge sys_clk) disable iff (rst)
    busy_fall |=> ctl_ff[CTL_DONE] && !ctl_ff[CTL_BUSY];
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done flag not set at busy fall");
  property p_done_sticky;
    @(posedge sys_clk) disable iff (rst)
    ctl_ff[CTL_DONE] && !(sfr_wr && sfr_addr == CONV_CONTROL_ADDR) |=> ctl_ff[CTL_DONE];
  endproperty
  a_done_sticky: assert property (p_done_sticky)
    else $error("done flag cleared by hardware");
  property p_soft_only;
    @(posedge sys_clk) disable iff (rst)
    state_ff == SACC_IDLE && src != SRC_SOFT && !timer2_overflow && !timer3_overflow
      && !external_convert_strobe |=> state_ff == SACC_IDLE;
  endproperty
  a_soft_only: assert property (p_soft_only)
    else $error("start without a selected source");
  property p_track_len;
    @(posedge sys_clk) disable iff (rst)
    state_ff == SACC_TRACK && cfg_ff[7:CFG_PER_LSB] == 3'h0 && ctl_ff[CTL_ON]
      && $past(state_ff) == SACC_IDLE |-> s_track3 ##1 state_ff == SACC_CONV;
  endproperty
  a_track_len: assert property (p_track_len)
    else $error("tracking not three sar clocks");
  property p_cont_track;
    @(posedge sys_clk) disable iff (rst)
    ctl_ff[CTL_ON] && !ctl_ff[CTL_TRACK] && !chip_standby && state_ff == SACC_IDLE |-> track_on;
  endproperty
  a_cont_track: assert property (p_cont_track)
    else $error("continuous tracking dropped");
  property p_strobe_hold;
    @(posedge sys_clk) disable iff (rst)
    ctl_ff[CTL_TRACK] && src == SRC_STROBE && external_convert_strobe |-> !track_on;
  endproperty
  a_strobe_hold: assert property (p_strobe_hold)
    else $error("tracking while strobe high");
  property p_temp_sel;
    @(posedge sys_clk) disable iff (rst)
    sel_ff[3] |-> mux_positive == 4'h8 && !mux_differential;
  endproperty
  a_temp_sel: assert property (p_temp_sel)
    else $error("temperature channel misrouted");
endmodule // sacc_top
`default_nettype wire

// file: verif/sacc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_core_model
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // block side
  input wire logic analog_power_on,
  input wire logic track_on,
  input wire logic [3:0] mux_positive,
  input wire logic mux_differential,
  input wire logic sar_step,
  // reference side, set up by software before any conversion
  input wire logic analog_bias_on,
  output logic [9:0] core_result
);
  logic seen;
  logic flip;
  always_ff @(posedge sys_clk)
  begin
    flip <= rst ? 1'b0 : !flip;
    seen <= !rst && !track_on && (seen || sar_step);
  end
  // no valid code until a step has run, so a stale sample cannot match
  assign core_result = (analog_power_on && analog_bias_on && seen) ?
    {mux_differential, mux_positive, 5'h0B} : {10{flip}};
endmodule // sacc_core_model
`default_nettype wire

// file: verif/sacc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_top_tb
  import sacc_pkg::*;
;
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; $display("FAIL %s exp %0h got %0h", n, e, s); end end
  logic sys_clk, rst, sfr_wr, t3, t2, stb, stby, irq_en, rd_req, meas;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, ev;
  logic [7:0] exp_q[$];
  logic [3:0] pc, mpos;
  logic [2:0] gain;
  logic pwr, trk_on, mdif, mneg, step, irq, bias;
  logic [9:0] cres;
  int fails = 0, num_checks = 0, seed = 32'h70FAC3CB;
  int steps, gap, trk, bad, irqs, pexp;
  sacc_top #(.RES_BITS(10)) i_dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer3_overflow(t3),
    .timer2_overflow(t2), .external_convert_strobe(stb), .chip_standby(stby),
    .done_irq_enable(irq_en), .analog_power_on(pwr), .track_on(trk_on), .mux_positive(mpos),
    .mux_negative_odd(mneg), .mux_differential(mdif), .gain_code(gain), .sar_step(step),
    .core_result(cres), .conversion_done_irq(irq));
  sacc_core_model i_core (.sys_clk(sys_clk), .rst(rst), .analog_power_on(pwr),
    .analog_bias_on(bias), .track_on(trk_on), .mux_positive(mpos),
    .mux_differential(mdif), .sar_step(step), .core_result(cres));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic dif(input logic [3:0] ch);
    dif = !ch[3] && pc[ch[2:1]];
  endfunction
  function automatic logic [3:0] pos(input logic [3:0] ch);
    pos = ch[3] ? 4'h8 : (dif(ch) ? {ch[3:1], 1'b0} : ch);
  endfunction
  // reads are judged one edge later, when the addressed value has settled
  always @(posedge sys_clk)
  begin
    if (rd_req)
    begin
      ev = exp_q.pop_front();
      `CHK("sfr_rdata", ev, sfr_rdata)
    end
    if (meas)
    begin
      trk += trk_on;
      irqs += irq;
      if (step)
      begin
        bad += (steps > 0 && gap != pexp) || trk_on;
        steps++;
        gap = 1;
      end
      else
        gap++;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr <= a;
    rd_req <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    rd_req <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic conv(input logic [1:0] src, input logic tm, input logic [2:0] c,
    input logic lj, input logic [3:0] ch);
    logic [9:0] r;
    logic [15:0] w;
    logic [7:0] cv;
    int n;
    cv = {1'b1, tm, 2'b01, src, 1'b0, lj};
    r = {dif(ch), pos(ch), 5'h0B};
    w = lj ? {r, 6'h00} : {{6{r[9]}}, r};
    pexp = c[2] ? 16 : 1 << c[1:0];
    wr(PAIR_CONFIG_ADDR, {4'h0, pc});
    wr(CHAN_SELECT_ADDR, {4'h0, ch});
    wr(CONV_CONFIG_ADDR, {c, 5'h00});
    stb <= 1'b0;
    irq_en <= 1'($random(seed));
    // set up without the busy bit so that an old source field cannot fire early
    wr(CONV_CONTROL_ADDR, cv & 8'hEF);
    // with a hardware source selected a busy write must be ignored
    if (src != SRC_SOFT)
      wr(CONV_CONTROL_ADDR, cv);
    rd(CONV_CONTROL_ADDR, cv & 8'hEF);
    @(negedge sys_clk);
    `CHK("track_on", !tm || src == SRC_STROBE, trk_on)
    @(posedge sys_clk);
    steps = 0;
    trk = 0;
    bad = 0;
    irqs = 0;
    sfr_addr <= CONV_CONTROL_ADDR;
    sfr_wdata <= cv;
    sfr_wr <= src == SRC_SOFT;
    t3 <= src == SRC_T3;
    t2 <= src == SRC_T2;
    stb <= src == SRC_STROBE;
    meas <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    t3 <= 1'b0;
    t2 <= 1'b0;
    for (n = 0; n < 2000 && sfr_rdata[CTL_DONE] !== 1'b1; n++)
    begin
      @(negedge sys_clk);
      bad += n > 2 && sfr_rdata[CTL_BUSY] !== 1'b1 && sfr_rdata[CTL_DONE] !== 1'b1;
    end
    @(posedge sys_clk);
    rd(CONV_CONTROL_ADDR, cv ^ 8'h30);
    rd(RESULT_HIGH_ADDR, w[15:8]);
    rd(RESULT_LOW_ADDR, w[7:0]);
    meas <= 1'b0;
    `CHK("steps", CONV_SAR_CLKS, steps)
    `CHK("bad", 0, bad)
    `CHK("irqs", int'(irq_en), irqs)
    if (tm && src != SRC_STROBE)
      `CHK("trk", 1, trk > 2 * pexp && trk <= 4 * pexp)
    if (tm && src == SRC_STROBE)
      `CHK("track_on", 1'b0, trk_on)
    wr(CONV_CONTROL_ADDR, cv & 8'hCF);
    rd(CONV_CONTROL_ADDR, cv & 8'hCF);
  endtask
  task automatic conclude;
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(100 * 60000);
    fails++;
    conclude();
  end
  initial
  begin
    {rst, sfr_wr, t3, t2, stb, stby, irq_en, rd_req, meas} = 9'h100;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    pc = 4'h0;
    bias = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    bias <= 1'b1;
    @(posedge sys_clk);
    `CHK("power", 1'b0, pwr)
    `CHK("gain", GAIN_X1, gain)
    wr(RESULT_HIGH_ADDR, 8'hFF);
    rd(PAIR_CONFIG_ADDR, PAIR_CONFIG_RST);
    rd(CONV_CONFIG_ADDR, CONV_CONFIG_RST);
    rd(CHAN_SELECT_ADDR, CHAN_SELECT_RST);
    rd(CONV_CONTROL_ADDR, CONV_CONTROL_RST);
    rd(RESULT_HIGH_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    wr(CHAN_SELECT_ADDR, 8'h08);
    for (int g = 0; g < 8; g++)
    begin
      wr(CONV_CONFIG_ADDR, {5'h1B, g[2:0]});
      rd(CONV_CONFIG_ADDR, {5'h18, g[2:0]});
      `CHK("gain", g[2:0], gain)
    end
    for (int i = 0; i < 16; i++)
    begin
      pc = 4'($random(seed));
      wr(PAIR_CONFIG_ADDR, {4'hF, pc});
      wr(CHAN_SELECT_ADDR, {4'hA, i[3:0]});
      rd(PAIR_CONFIG_ADDR, {4'h0, pc});
      rd(CHAN_SELECT_ADDR, {4'h0, i[3:0]});
      `CHK("mux_positive", pos(i[3:0]), mpos)
      `CHK("mux_differential", dif(i[3:0]), mdif)
      `CHK("mux_negative_odd", dif(i[3:0]), mneg)
    end
    // period code steps by three so all eight codes are used, each with one fixed source
    for (int k = 0; k < 16; k++)
    begin
      pc = 4'($random(seed));
      conv(k[1:0], k[2], 3'(k * 3), 1'($random(seed)), 4'($random(seed)));
    end
    // fastest sar clock with timed tracking is the case the track length check watches
    conv(SRC_T3, 1'b1, 3'h0, 1'b0, 4'h1);
    wr(CONV_CONTROL_ADDR, 8'h80);
    @(negedge sys_clk);
    `CHK("track_on", 1'b1, trk_on)
    @(posedge sys_clk);
    stby <= 1'b1;
    @(negedge sys_clk);
    `CHK("track_on", 1'b0, trk_on)
    @(posedge sys_clk);
    stby <= 1'b0;
    wr(CONV_CONTROL_ADDR, 8'h10);
    rd(CONV_CONTROL_ADDR, 8'h00);
    @(negedge sys_clk);
    `CHK("power", 1'b0, pwr)
    `CHK("track_on", 1'b0, trk_on)
    conclude();
  end
endmodule // sacc_top_tb
`default_nettype wire
